//--- common/edm_defs.svh
// Purpose: constants for the edm relay sequencer
// Assumes: 25 MHz system clock
// Notes:   times in ms, cycle counts derived in the top
`ifndef EDM_DEFS_SVH
`define EDM_DEFS_SVH
`define EDM_CLK_KHZ      25000
`define EDM_T_FLT_MS     100
`define EDM_T_HOLD_MS    20
`define EDM_T_RET_MS     100
`define EDM_T_STOP_MS    100
`define EDM_T_STALL_MS   1000
`define EDM_BURN_PULSES  32'sd20
`define EDM_A_CTRL       6'h00
`define EDM_A_TARGET     6'h04
`define EDM_A_RETDIST    6'h08
`define EDM_A_ZTOP       6'h0C
`define EDM_A_REVFLT     6'h10
`define EDM_A_DWELL      6'h14
`define EDM_A_SPARK      6'h18
`define EDM_A_GPOUT      6'h1C
`define EDM_A_STATUS     6'h20
`define EDM_A_ZPOS       6'h24
`define EDM_A_ZMAX       6'h28
`define EDM_B_EN         0
`define EDM_B_APP        1
`define EDM_B_LIN        2
`define EDM_B_DISP       3
`define EDM_B_DWEN       4
`define EDM_B_SPEN       5
`define EDM_B_RDEN       6
`define EDM_B_ZTEN       7
`define EDM_B_RVEN       8
`define EDM_B_SPIN       9
`define EDM_CTRL_RST     10'h00F
`endif

//--- common/edm_pkg.sv
// Purpose: types of the edm relay sequencer
// Assumes: nothing
// Notes:   gray codes along disabled-ready-burn-dwell-stop-retract
package edm_pkg;
    typedef enum logic [2:0] {
        ST_DIS   = 3'h0,
        ST_READY = 3'h1,
        ST_BURN  = 3'h3,
        ST_DWELL = 3'h2,
        ST_STOP  = 3'h6,
        ST_RET   = 3'h7,
        ST_FAULT = 3'h5
    } edm_st_t;
endpackage

//--- verilog/edm_quad.sv
// Purpose: quadrature decoder and z position counter
// Assumes: encoder edges slower than two clocks
// Notes:   up count means ram moving up
module edm_quad (
    input  wire logic        clk,   // system clock
    input  wire logic        rst,   // sync reset
    input  wire logic        enc_a, // encoder a pin
    input  wire logic        enc_b, // encoder b pin
    output logic signed [31:0] pos  // z position
);
    import edm_pkg::*;
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] prev_r;
    logic       up;
    logic       dn;

    // ******************
    // pin synchroniser
    // ******************
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r   <= 2'h0;
            s2_r   <= 2'h0;
            prev_r <= 2'h0;
        end else begin
            s1_r   <= {enc_a, enc_b};
            s2_r   <= s1_r;
            prev_r <= s2_r;
        end
    end

    // gray step forward: 00-01-11-10; illegal double steps dropped
    assign up = (prev_r == 2'h0 && s2_r == 2'h1) || (prev_r == 2'h1 && s2_r == 2'h3) ||
                (prev_r == 2'h3 && s2_r == 2'h2) || (prev_r == 2'h2 && s2_r == 2'h0);
    assign dn = (prev_r == 2'h1 && s2_r == 2'h0) || (prev_r == 2'h3 && s2_r == 2'h1) ||
                (prev_r == 2'h2 && s2_r == 2'h3) || (prev_r == 2'h0 && s2_r == 2'h2);

    always_ff @(posedge clk) begin
        if (rst) begin
            pos <= 32'sh0;
        end else if (up) begin
            pos <= pos + 32'sh1;
        end else if (dn) begin
            pos <= pos - 32'sh1;
        end
    end
endmodule

//--- verilog/edm_relay_seq.sv
// Purpose: edm retract, dwell and position hold relay sequencer
// Assumes: z counts up when ram rises; relay high = energized
// Notes:   register port, read data one cycle after strobe
// Overview of operation
// [RL1] retract relay energized at power up
// [RL2] dwell relay de-energized at power up
// [RL3] position hold relay de-energized at power up
// [RL4] power loss drops every relay
// [RL5] reverse fault: retract relay off 0.1 s
// [RL6] hold relay only during dwell
// [RL7] hold on when at or below target
// [RL8] retract to top position or distance
// [RL9] dwell by time or until spark-out
// [RL10] run only when enabled and display ok
// [RL11] edm takes three outputs, seven remain
// [RL12] spindle control off in edm application
// [RL13] reverse fault distance above max depth
// [RL14] spark-out time after sparking stops
// [RL15] z axis must be linear
// [RL16] ready, burn, dwell, retract cycle
// [RL17] burn after 20 pulses downward above target
// [RL18] hold re-evaluated every 20 ms
// [RL19] retract relay off at least 100 ms
// [RL20] relays registered on system clock
//
// Chosen here: the strobed register port and the placing of the registers.
`include "edm_defs.svh"
module edm_relay_seq #(
    parameter int unsigned MS_CYC    = `EDM_CLK_KHZ,
    parameter int unsigned FLT_CYC   = `EDM_T_FLT_MS * `EDM_CLK_KHZ,
    parameter int unsigned HOLD_CYC  = `EDM_T_HOLD_MS * `EDM_CLK_KHZ,
    parameter int unsigned RET_CYC   = `EDM_T_RET_MS * `EDM_CLK_KHZ,
    parameter int unsigned STOP_CYC  = `EDM_T_STOP_MS * `EDM_CLK_KHZ,
    parameter int unsigned STALL_CYC = `EDM_T_STALL_MS * `EDM_CLK_KHZ
) (
    input  wire logic           SYS_CLK,     // 25 MHz clock
    input  wire logic           RST,         // sync reset, high
    input  wire logic           ENC_A,       // z encoder a
    input  wire logic           ENC_B,       // z encoder b
    input  wire logic           SPARK,       // spark detector
    input  wire logic           PWR_OK,      // supply good
    input  wire logic [5:0]     ADDR,        // register address
    input  wire logic [31:0]    WDATA,       // write data
    input  wire logic           WR,          // write strobe
    input  wire logic           RD,          // read strobe
    output logic      [31:0]    RDATA,       // read data
    output logic                RETRACT_RLY, // 1 = do not retract
    output logic                DWELL_RLY,   // 1 = dwell
    output logic                HOLD_RLY,    // 1 = below target
    output logic      [9:0]     SW_OUT,      // switching outputs
    output logic                SPINDLE_EN,  // spindle control allowed
    output edm_pkg::edm_st_t    STATE        // cycle state
);
    import edm_pkg::*;

    // ******************
    // declarations
    // ******************
    logic signed [31:0] z_s;
    logic signed [31:0] target_r;
    logic signed [31:0] retdist_r;
    logic signed [31:0] ztop_r;
    logic signed [31:0] revflt_r;
    logic signed [31:0] zmax_r;
    logic signed [31:0] ref_r;
    logic signed [31:0] zprev_r;
    logic [9:0]  ctrl_r;
    logic [15:0] dwell_ms_r;
    logic [15:0] spark_ms_r;
    logic [9:0]  gp_r;
    logic [1:0]  spk_sync_r;
    logic [1:0]  pwr_sync_r;
    edm_st_t     st_r;
    edm_st_t     st_nxt;
    logic [31:0] tmr_r;
    logic [31:0] ms_cnt_r;
    logic [31:0] hs_r;
    logic [31:0] stall_r;
    logic [15:0] dw_cnt_r;
    logic [15:0] sp_cnt_r;
    logic        ret_r;
    logic        dwl_r;
    logic        hold_r;
    logic        ret_nxt;
    logic        dwl_nxt;
    logic        hold_nxt;
    logic [9:0]  sw_r;
    logic        spin_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_mux;

    wire spark_s = spk_sync_r[1];
    wire pwr_s   = pwr_sync_r[1];
    wire edm_app = ctrl_r[`EDM_B_APP];
    wire act     = ctrl_r[`EDM_B_EN] & edm_app & ctrl_r[`EDM_B_LIN] &
                   ctrl_r[`EDM_B_DISP] & pwr_s; // see [RL10] see [RL15]
    wire ms_tick = (ms_cnt_r == MS_CYC - 1);
    wire st_chg  = (st_nxt != st_r);
    wire dw_any  = ctrl_r[`EDM_B_DWEN] | ctrl_r[`EDM_B_SPEN];

    // ******************
    // register port
    // ******************
    wire wr_ctrl  = WR && ADDR == `EDM_A_CTRL;
    wire wr_tgt   = WR && ADDR == `EDM_A_TARGET;
    wire wr_rdist = WR && ADDR == `EDM_A_RETDIST;
    wire wr_ztop  = WR && ADDR == `EDM_A_ZTOP;
    wire wr_rvf   = WR && ADDR == `EDM_A_REVFLT;
    wire wr_dwell = WR && ADDR == `EDM_A_DWELL;
    wire wr_spark = WR && ADDR == `EDM_A_SPARK;
    wire wr_gp    = WR && ADDR == `EDM_A_GPOUT;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ctrl_r     <= `EDM_CTRL_RST;
            target_r   <= 32'sh0;
            retdist_r  <= 32'sh0;
            ztop_r     <= 32'sh0;
            revflt_r   <= 32'sh0;
            dwell_ms_r <= 16'h0;
            spark_ms_r <= 16'h0;
            gp_r       <= 10'h000;
        end else begin
            if (wr_ctrl)  ctrl_r     <= WDATA[9:0];
            if (wr_tgt)   target_r   <= WDATA;
            if (wr_rdist) retdist_r  <= WDATA;
            if (wr_ztop)  ztop_r     <= WDATA;
            if (wr_rvf)   revflt_r   <= WDATA; // see [RL13]
            if (wr_dwell) dwell_ms_r <= WDATA[15:0];
            if (wr_spark) spark_ms_r <= WDATA[15:0]; // see [RL14]
            if (wr_gp)    gp_r       <= WDATA[9:0];
        end
    end

    wire [31:0] status_w = {23'h0, hold_r, dwl_r, ret_r, 3'h0, st_r};

    assign rd_mux = (ADDR == `EDM_A_CTRL)    ? {22'h0, ctrl_r} :
                    (ADDR == `EDM_A_TARGET)  ? target_r :
                    (ADDR == `EDM_A_RETDIST) ? retdist_r :
                    (ADDR == `EDM_A_ZTOP)    ? ztop_r :
                    (ADDR == `EDM_A_REVFLT)  ? revflt_r :
                    (ADDR == `EDM_A_DWELL)   ? {16'h0, dwell_ms_r} :
                    (ADDR == `EDM_A_SPARK)   ? {16'h0, spark_ms_r} :
                    (ADDR == `EDM_A_GPOUT)   ? {22'h0, gp_r} :
                    (ADDR == `EDM_A_STATUS)  ? status_w :
                    (ADDR == `EDM_A_ZPOS)    ? z_s :
                    (ADDR == `EDM_A_ZMAX)    ? zmax_r : 32'h0;

    // read data valid only in the cycle after the strobe
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= RD ? rd_mux : 32'h0;
        end
    end

    // ******************
    // inputs
    // ******************
    edm_quad u_quad (
        .clk   (SYS_CLK),
        .rst   (RST),
        .enc_a (ENC_A),
        .enc_b (ENC_B),
        .pos   (z_s)
    );

    // pwr sync resets to good so the power-up relay states hold
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            spk_sync_r <= 2'h0;
            pwr_sync_r <= 2'h3;
        end else begin
            spk_sync_r <= {spk_sync_r[0], SPARK};
            pwr_sync_r <= {pwr_sync_r[0], PWR_OK};
        end
    end

    // ******************
    // sequencing conditions
    // ******************
    wire below_tgt = (z_s <= target_r);
    wire burn_go   = (z_s > target_r) && (ref_r - z_s > `EDM_BURN_PULSES); // see [RL17]
    wire rev_flt   = ctrl_r[`EDM_B_RVEN] && (z_s - zmax_r > revflt_r); // see [RL13]
    wire dw_done   = (ctrl_r[`EDM_B_DWEN] && dw_cnt_r >= dwell_ms_r) ||
                     (ctrl_r[`EDM_B_SPEN] && sp_cnt_r >= spark_ms_r); // see [RL9] see [RL14]
    wire rd_hit    = ctrl_r[`EDM_B_RDEN] && (z_s >= target_r + retdist_r);
    wire zt_hit    = ctrl_r[`EDM_B_ZTEN] && (z_s >= ztop_r);
    wire ret_none  = !ctrl_r[`EDM_B_RDEN] && !ctrl_r[`EDM_B_ZTEN];
    wire ret_done  = rd_hit || zt_hit || ret_none; // see [RL8]
    wire stalled   = (stall_r >= STALL_CYC - 1);
    wire hold_smp  = (st_r == ST_DWELL) && (hs_r == 32'h0); // see [RL18]

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_DIS: begin
                st_nxt = ST_READY; // see [RL16]
            end
            ST_READY: begin
                if (burn_go) st_nxt = ST_BURN;
            end
            ST_BURN: begin
                if (rev_flt) st_nxt = ST_FAULT;
                else if (below_tgt) st_nxt = dw_any ? ST_DWELL : ST_RET;
            end
            ST_DWELL: begin
                if (rev_flt) st_nxt = ST_FAULT;
                else if (dw_done) st_nxt = ST_STOP;
            end
            ST_STOP: begin
                if (tmr_r >= STOP_CYC - 1) st_nxt = ST_RET;
            end
            ST_RET: begin
                if (stalled) st_nxt = ST_READY;
                else if (tmr_r >= RET_CYC - 1 && ret_done) st_nxt = ST_READY; // see [RL19]
            end
            ST_FAULT: begin
                if (tmr_r >= FLT_CYC - 1) st_nxt = ST_READY; // see [RL5]
            end
            default: begin
                st_nxt = ST_DIS;
            end
        endcase
        if (!act) st_nxt = ST_DIS; // see [RL10]
    end

    // retract relay on only in ready, burn, dwell and stop with power good; the post-dwell delay still holds burn
    assign ret_nxt  = pwr_s && (st_nxt == ST_READY || st_nxt == ST_BURN ||
                                st_nxt == ST_DWELL || st_nxt == ST_STOP); // see [RL4] see [RL5] see [RL19]
    assign dwl_nxt  = pwr_s && (st_nxt == ST_DWELL); // see [RL9] see [RL4]
    assign hold_nxt = pwr_s && (st_nxt == ST_DWELL) &&
                      (hold_smp ? below_tgt : hold_r); // see [RL6] see [RL7]

    // ******************
    // state and timers
    // ******************
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_r <= ST_READY;
            tmr_r <= 32'h0;
        end else begin
            st_r <= st_nxt; // see [RL16]
            tmr_r <= st_chg ? 32'h0 : tmr_r + 32'h1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST || ms_tick) begin
            ms_cnt_r <= 32'h0;
        end else begin
            ms_cnt_r <= ms_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST || st_r != ST_DWELL || hs_r == HOLD_CYC - 1) begin
            hs_r <= 32'h0;
        end else begin
            hs_r <= hs_r + 32'h1; // see [RL18]
        end
    end

    // dwell and spark-out ms counters, saturate at full scale
    always_ff @(posedge SYS_CLK) begin
        if (RST || st_r != ST_DWELL) begin
            dw_cnt_r <= 16'h0;
            sp_cnt_r <= 16'h0;
        end else begin
            if (ms_tick && dw_cnt_r != 16'hFFFF) dw_cnt_r <= dw_cnt_r + 16'h1;
            if (spark_s) sp_cnt_r <= 16'h0; // see [RL14]
            else if (ms_tick && sp_cnt_r != 16'hFFFF) sp_cnt_r <= sp_cnt_r + 16'h1;
        end
    end

    // retract stall watch: ram not moving for one second
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            zprev_r <= 32'sh0;
            stall_r <= 32'h0;
        end else begin
            zprev_r <= z_s;
            if (st_r != ST_RET || z_s != zprev_r) stall_r <= 32'h0;
            else if (!stalled) stall_r <= stall_r + 32'h1;
        end
    end

    // ******************
    // depth tracking
    // ******************
    wire zmax_rst = (st_r == ST_DIS && st_nxt == ST_READY) ||
                    (st_r == ST_READY && st_nxt == ST_BURN);

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            zmax_r <= 32'sh0;
            ref_r  <= 32'sh0;
        end else begin
            if (zmax_rst) zmax_r <= z_s;
            else if (z_s < zmax_r) zmax_r <= z_s;
            // highest point seen in ready is the burn start reference
            if (st_r != ST_READY) ref_r <= z_s;
            else if (z_s > ref_r) ref_r <= z_s;
        end
    end

    // ******************
    // relay and switching outputs
    // ******************
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ret_r  <= 1'b1; // see [RL1]
            dwl_r  <= 1'b0; // see [RL2]
            hold_r <= 1'b0; // see [RL3]
            sw_r   <= 10'h000;
            spin_r <= 1'b0;
        end else begin
            ret_r  <= ret_nxt; // see [RL20]
            dwl_r  <= dwl_nxt;
            hold_r <= hold_nxt;
            sw_r   <= edm_app ? {ret_nxt, dwl_nxt, hold_nxt, gp_r[6:0]} : gp_r; // see [RL11]
            spin_r <= ctrl_r[`EDM_B_SPIN] && !edm_app; // see [RL12]
        end
    end

    assign RETRACT_RLY = ret_r;
    assign DWELL_RLY   = dwl_r;
    assign HOLD_RLY    = hold_r;
    assign SW_OUT      = sw_r;
    assign SPINDLE_EN  = spin_r;
    assign STATE       = st_r;
    assign RDATA       = rdata_r;

    // ******************
    // assertions
    // ******************
    property p_pwrup_ret;
        @(posedge SYS_CLK) $fell(RST) |-> RETRACT_RLY;
    endproperty
    a_pwrup_ret: assert property (p_pwrup_ret) else $error("retract not energized at power up"); // see [RL1]

    property p_pwrup_dwl;
        @(posedge SYS_CLK) $fell(RST) |-> !DWELL_RLY;
    endproperty
    a_pwrup_dwl: assert property (p_pwrup_dwl) else $error("dwell energized at power up"); // see [RL2]

    property p_pwrup_hold;
        @(posedge SYS_CLK) $fell(RST) |-> !HOLD_RLY;
    endproperty
    a_pwrup_hold: assert property (p_pwrup_hold) else $error("hold energized at power up"); // see [RL3]

    property p_pwr_loss;
        @(posedge SYS_CLK) disable iff (RST)
            !pwr_s |=> !RETRACT_RLY && !DWELL_RLY && !HOLD_RLY;
    endproperty
    a_pwr_loss: assert property (p_pwr_loss) else $error("relay driven after power loss"); // see [RL4]

    property p_fault_ret;
        @(posedge SYS_CLK) disable iff (RST) st_r == ST_FAULT |-> !RETRACT_RLY;
    endproperty
    a_fault_ret: assert property (p_fault_ret) else $error("retract energized in fault"); // see [RL5]

    property p_hold_dwell;
        @(posedge SYS_CLK) disable iff (RST) HOLD_RLY |-> DWELL_RLY && st_r == ST_DWELL;
    endproperty
    a_hold_dwell: assert property (p_hold_dwell) else $error("hold outside dwell"); // see [RL6]

    sequence s_go;
        st_r == ST_READY ##1 st_r == ST_BURN;
    endsequence
    property p_burn_go;
        @(posedge SYS_CLK) disable iff (RST)
            s_go |-> $past(z_s) > $past(target_r) && $past(ref_r) - $past(z_s) > 32'sd20;
    endproperty
    a_burn_go: assert property (p_burn_go) else $error("burn entered without descent"); // see [RL17]

    sequence s_ret_in;
        st_r != ST_RET ##1 st_r == ST_RET;
    endsequence
    property p_ret_min;
        @(posedge SYS_CLK) disable iff (RST) s_ret_in |-> (!RETRACT_RLY && st_r == ST_RET)[*8];
    endproperty
    a_ret_min: assert property (p_ret_min) else $error("retract ended early"); // see [RL19]

    property p_spin;
        @(posedge SYS_CLK) disable iff (RST) edm_app |=> !SPINDLE_EN;
    endproperty
    a_spin: assert property (p_spin) else $error("spindle enabled in edm"); // see [RL12]

    property p_inact;
        @(posedge SYS_CLK) disable iff (RST)
            !act |=> st_r == ST_DIS && !RETRACT_RLY && !DWELL_RLY && !HOLD_RLY;
    endproperty
    a_inact: assert property (p_inact) else $error("sequencing while inactive"); // see [RL10]
endmodule

//--- sim/edm_ram_model.sv
// Purpose: ram and z encoder of the machine, seen from the sequencer
// Assumes: one quadrature step every four clocks
// Notes:   goal is set by the bench, encoder pins follow gray code of pos
module edm_ram_model (
    input  wire logic               clk,   // system clock
    input  wire logic signed [31:0] goal,  // commanded ram position
    output logic                    enc_a, // encoder a
    output logic                    enc_b, // encoder b
    output logic signed [31:0]      pos    // ram position
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]         cnt_r = 2'h0;
    logic signed [31:0] pos_r = 32'sh0;
    // step slower than two clocks so the decoder never misses an edge
    always_ff @(posedge clk) begin
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r == 2'h3) begin
            if (pos_r < goal) pos_r <= pos_r + 32'sh1;
            else if (pos_r > goal) pos_r <= pos_r - 32'sh1;
        end
    end
    assign pos = pos_r;
    // 00-01-11-10 going up
    assign enc_a = pos[1];
    assign enc_b = pos[1] ^ pos[0];
endmodule

//--- sim/edm_relay_seq_tb_top.sv
// Purpose: self-checking bench of the edm relay sequencer
// Assumes: shortened timer parameters, 1 ms = 4 clocks
// Notes:   ram moved through edm_ram_model, registers via strobe port
`include "edm_defs.svh"
module edm_relay_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import edm_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, spark = 1'b0, pwr_ok = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic ret_rly, dwl_rly, hold_rly, spin_en, enc_a, enc_b;
    logic [9:0] sw_out;
    logic signed [31:0] goal = 32'sh0, pos;
    edm_st_t state;
    int fail_count = 0, cmp_count = 0;
    always #20 sys_clk = ~sys_clk;
    edm_relay_seq #(.MS_CYC(4), .FLT_CYC(20), .HOLD_CYC(10), .RET_CYC(20), .STOP_CYC(20),
                    .STALL_CYC(50)) edm_relay_seq_inst (
        .SYS_CLK(sys_clk), .RST(rst), .ENC_A(enc_a), .ENC_B(enc_b), .SPARK(spark),
        .PWR_OK(pwr_ok), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .RETRACT_RLY(ret_rly), .DWELL_RLY(dwl_rly), .HOLD_RLY(hold_rly), .SW_OUT(sw_out),
        .SPINDLE_EN(spin_en), .STATE(state));
    edm_ram_model edm_ram_model_inst (.clk(sys_clk), .goal(goal), .enc_a(enc_a), .enc_b(enc_b),
                                      .pos(pos));
    // **********************
    // tasks
    // **********************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic move(input int g, input int settle);
        int n;
        @(posedge sys_clk);
        goal <= g;
        n = 0;
        while (pos != g && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 2000) begin
            fail_count++;
            $display("BAD move expected %0d seen %0d", g, pos);
        end
        repeat (settle) @(posedge sys_clk);
        #1;
    endtask
    task automatic relays(input logic [2:0] exp);
        chk("relays", {29'h0, exp}, {29'h0, ret_rly, dwl_rly, hold_rly});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // **********************
    // watchdog
    // **********************
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        end_sim();
    end
    // **********************
    // scenarios
    // **********************
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        wt(3);
        relays(3'b100);
        chk("state", ST_READY, state);
        chk("sw_out", 10'h200, sw_out);
        chk("spindle", 1'b0, spin_en);
        rd_reg(`EDM_A_CTRL, rv);
        chk("ctrl", 32'h0000000F, rv);
        rd_reg(6'h3C, rv);
        chk("unmapped", 32'h0, rv);
        // plain burn, retract by distance
        wr_reg(`EDM_A_TARGET, -32'sd40);
        wr_reg(`EDM_A_RETDIST, 32'h0000000A);
        wr_reg(`EDM_A_CTRL, 32'h0000004F);
        move(-25, 10);
        chk("state", ST_BURN, state);
        relays(3'b100);
        move(-40, 10);
        chk("state", ST_RET, state);
        relays(3'b000);
        rd_reg(`EDM_A_ZPOS, rv);
        chk("zpos", -32'sd40, rv);
        wt(15);
        chk("state", ST_RET, state);
        move(-28, 10);
        chk("state", ST_READY, state);
        relays(3'b100);
        // dwell with hold relay
        wr_reg(`EDM_A_TARGET, -32'sd60);
        wr_reg(`EDM_A_DWELL, 32'h00000014);
        wr_reg(`EDM_A_CTRL, 32'h0000001F);
        move(-60, 10);
        chk("state", ST_DWELL, state);
        relays(3'b111);
        move(-56, 10);
        relays(3'b110);
        wt(60);
        chk("state", ST_STOP, state);
        relays(3'b100);
        wt(20);
        chk("state", ST_RET, state);
        chk("ret_rly", 1'b0, ret_rly);
        wt(30);
        chk("state", ST_READY, state);
        // reverse fault
        wr_reg(`EDM_A_TARGET, -32'sd200);
        wr_reg(`EDM_A_REVFLT, 32'h00000005);
        wr_reg(`EDM_A_CTRL, 32'h0000010F);
        move(-80, 10);
        chk("state", ST_BURN, state);
        rd_reg(`EDM_A_ZMAX, rv);
        chk("zmax", -32'sd80, rv);
        move(-74, 6);
        chk("state", ST_FAULT, state);
        chk("ret_rly", 1'b0, ret_rly);
        wt(30);
        chk("state", ST_READY, state);
        chk("ret_rly", 1'b1, ret_rly);
        // outputs, spindle and enable
        wr_reg(`EDM_A_GPOUT, 32'h000003FF);
        wr_reg(`EDM_A_CTRL, 32'h0000020F);
        wt(3);
        chk("sw_out", 10'h27F, sw_out);
        chk("spindle", 1'b0, spin_en);
        wr_reg(`EDM_A_CTRL, 32'h0000020D);
        wt(3);
        chk("spindle", 1'b1, spin_en);
        chk("sw_out", 10'h3FF, sw_out);
        wr_reg(`EDM_A_CTRL, 32'h0000000E);
        wt(3);
        chk("state", ST_DIS, state);
        relays(3'b000);
        wr_reg(`EDM_A_CTRL, 32'h0000000B);
        wt(3);
        chk("state", ST_DIS, state);
        wr_reg(`EDM_A_CTRL, 32'h0000000F);
        wt(3);
        chk("state", ST_READY, state);
        // supply loss drops every relay
        @(posedge sys_clk);
        pwr_ok <= 1'b0;
        wt(6);
        relays(3'b000);
        chk("sw_out", 10'h07F, sw_out);
        @(posedge sys_clk);
        pwr_ok <= 1'b1;
        wt(6);
        chk("ret_rly", 1'b1, ret_rly);
        // spark-out dwell, retract to top position
        wr_reg(`EDM_A_TARGET, -32'sd100);
        wr_reg(`EDM_A_SPARK, 32'h00000005);
        wr_reg(`EDM_A_ZTOP, -32'sd90);
        wr_reg(`EDM_A_CTRL, 32'h000000AF);
        spark <= 1'b1;
        move(-100, 10);
        chk("state", ST_DWELL, state);
        relays(3'b111);
        rd_reg(`EDM_A_STATUS, rv);
        chk("status", 32'h000001C2, rv);
        wt(1);
        chk("rdata idle", 32'h0, rdata);
        wt(40);
        chk("state", ST_DWELL, state);
        @(posedge sys_clk);
        spark <= 1'b0;
        wt(10);
        chk("state", ST_DWELL, state);
        wt(20);
        chk("state", ST_STOP, state);
        relays(3'b100);
        wt(20);
        chk("state", ST_RET, state);
        relays(3'b000);
        move(-85, 10);
        chk("state", ST_READY, state);
        relays(3'b100);
        end_sim();
    end
endmodule
